//--- logic/see_pkg.sv
// Package with constants shared by the serial EEPROM slave and its bus master
package see_pkg;
    localparam int          CLK_MHZ            = 200;
    localparam logic [3:0]  SEE_DEV_CODE       = 4'ha;
    localparam logic [2:0]  SEE_DEV_SEL        = 3'h0;
    localparam int          SEE_PAGE_BYTES     = 16;
    localparam int          SEE_MEM_BYTES      = 256;
    localparam int          SEE_SMALL_BYTES    = 128;
    localparam logic [7:0]  SEE_ERASED         = 8'hff;
    localparam int          INTERNAL_WRITE_TIME_US  = 5000;
    localparam int          POWER_UP_READY_DELAY_US = 1000;
    localparam int          WRITE_CYCLES       = INTERNAL_WRITE_TIME_US * CLK_MHZ;
    localparam int          READY_CYCLES       = POWER_UP_READY_DELAY_US * CLK_MHZ;
    localparam int          MST_HALF_CYCLES    = 16;

    typedef enum logic [2:0] {
        SEE_IDLE  = 3'b000,
        SEE_ADDR  = 3'b001,
        SEE_WORD  = 3'b011,
        SEE_DATA  = 3'b010,
        SEE_READ  = 3'b110,
        SEE_RACK  = 3'b111
    } see_state_t;

    typedef enum logic [2:0] {
        MST_IDLE  = 3'b000,
        MST_START = 3'b001,
        MST_BITS  = 3'b011,
        MST_STOP  = 3'b010,
        MST_DONE  = 3'b110
    } see_mst_state_t;
endpackage : see_pkg

//--- logic/see_bus_if.sv
// Two-wire bus between the slave and its master
interface see_bus_if;
    logic scl_o;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic sda;
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
    modport slave  (input scl_o, input sda, output sda_s_o, output sda_s_oe);
    modport master (output scl_o, input sda, output sda_m_o, output sda_m_oe);
endinterface : see_bus_if

//--- logic/see_slave.sv
// Serial EEPROM slave end: protocol decode, page buffer, memory and write cycle
// Function
// - Reset returns device to standby state
// - Sample on clock rise, drive after fall
// - Open-drain data, only pulls low
// - Master changes data only while clock low
// - Start and stop detection; stop ends command
// - Silent until a start is seen
// - Answer only address 1010000, last bit R/W
// - Ninth clock carries the acknowledge
// - Byte write acknowledges every received byte; data bytes get no acknowledge when protect is latched high
// - Stop launches write; busy withholds acknowledges
// - Page buffer 16 bytes, wraps in page
// - Page commits in one write cycle
// - Master polls by retrying after no-acknowledge
// - Protect sampled before first data byte
// - Protect high blocks all writes
// - Read address returns current address byte
// - Master no-ack then stop ends read
// - Selective read via address then restart
// - Sequential read increments and wraps memory
// - Small variant address does not wrap
// - Ready within power-up delay
module see_slave
    import see_pkg::*;
#(
    parameter int MEM_BYTES    = SEE_MEM_BYTES,
    parameter int WRITE_TIME   = WRITE_CYCLES,
    parameter int READY_TIME   = READY_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    see_bus_if.slave    bus,
    input  wire logic   wp,
    output logic        busy,
    output logic        ready
);
    localparam int AW = $clog2(MEM_BYTES);

    logic [7:0]    mem_ff [SEE_MEM_BYTES] = '{default: SEE_ERASED};
    logic [1:0]    wp_sy_ff;
    logic [7:0]    pbuf_ff [SEE_PAGE_BYTES];
    logic [SEE_PAGE_BYTES-1:0] pval_ff, nxt_pval;
    logic [2:0]    scl_sy_ff, sda_sy_ff;
    logic          scl_d_ff, sda_d_ff;
    see_state_t    st_ff, nxt_st;
    logic [3:0]    bit_ff, nxt_bit;
    logic [7:0]    sh_ff, nxt_sh;
    logic          ack_ff, nxt_ack;
    logic          rd_ff, nxt_rd;
    logic [7:0]    addr_ff, nxt_addr;
    logic          wpl_ff, nxt_wpl;
    logic          dirty_ff, nxt_dirty;
    logic          oe_ff, nxt_oe;
    logic          mack_ff, nxt_mack;
    logic [31:0]   wcnt_ff, nxt_wcnt;
    logic [31:0]   rcnt_ff, nxt_rcnt;
    logic          busy_ff, nxt_busy;
    logic          ready_ff, nxt_ready;
    logic          scl, sda, scl_rise, scl_fall, start_c, stop_c;
    logic          commit;

    function automatic logic [7:0] addr_inc(input logic [7:0] a);
        logic [7:0] n;
        n = a + 8'h01;
        if (MEM_BYTES == SEE_MEM_BYTES) return n;
        return (a == 8'(MEM_BYTES - 1)) ? a : n;
    endfunction : addr_inc

    assign scl      = scl_sy_ff[1];
    assign sda      = sda_sy_ff[1];
    assign scl_rise = scl && !scl_d_ff;
    assign scl_fall = !scl && scl_d_ff;
    assign start_c  = scl && scl_d_ff && !sda && sda_d_ff;
    assign stop_c   = scl && scl_d_ff && sda && !sda_d_ff;
    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = oe_ff;
    assign busy  = busy_ff;
    assign ready = ready_ff;

    always_comb begin
        nxt_st = st_ff; nxt_bit = bit_ff; nxt_sh = sh_ff; nxt_ack = ack_ff;
        nxt_rd = rd_ff; nxt_addr = addr_ff; nxt_wpl = wpl_ff; nxt_dirty = dirty_ff;
        nxt_oe = oe_ff; nxt_mack = mack_ff; nxt_pval = pval_ff; commit = 1'b0;
        nxt_busy = busy_ff; nxt_wcnt = wcnt_ff;
        nxt_ready = ready_ff;
        nxt_rcnt = (rcnt_ff == 32'(READY_TIME)) ? rcnt_ff : rcnt_ff + 32'h1;
        if (rcnt_ff == 32'(READY_TIME)) nxt_ready = 1'b1;
        if (busy_ff) begin
            nxt_wcnt = wcnt_ff + 32'h1;
            if (wcnt_ff == 32'(WRITE_TIME - 1)) begin
                nxt_busy = 1'b0;
                nxt_wcnt = 32'h0;
            end
        end
        if (!ready_ff) begin
            nxt_st = SEE_IDLE;
        end else if (stop_c) begin
            nxt_st = SEE_IDLE;
            nxt_oe = 1'b0;
            if (dirty_ff && !busy_ff) begin
                commit   = 1'b1;
                nxt_busy = 1'b1;
                nxt_wcnt = 32'h0;
            end
            nxt_dirty = 1'b0;
            nxt_pval  = '0;
        end else if (start_c) begin
            nxt_st = SEE_ADDR; nxt_bit = 4'h0; nxt_ack = 1'b0; nxt_oe = 1'b0;
            nxt_dirty = 1'b0; nxt_pval = '0;
        end else if (st_ff != SEE_IDLE) begin
            if (scl_rise) begin
                if (!ack_ff && st_ff != SEE_RACK) begin
                    nxt_sh  = {sh_ff[6:0], sda};
                    nxt_bit = bit_ff + 4'h1;
                end else if (st_ff == SEE_RACK || st_ff == SEE_READ) begin
                    nxt_mack = !sda;
                end
            end else if (scl_fall) begin
                nxt_oe = 1'b0;
                if (ack_ff) begin
                    nxt_ack = 1'b0;
                    nxt_bit = 4'h0;
                    if (st_ff == SEE_READ && !mack_ff) begin
                        nxt_st = SEE_IDLE;
                    end else if (st_ff == SEE_READ) begin
                        nxt_st = SEE_RACK;
                        nxt_oe = !mem_ff[addr_ff][7];
                        nxt_sh = mem_ff[addr_ff];
                    end else if (st_ff == SEE_RACK) begin
                        if (mack_ff) begin
                            nxt_oe = !mem_ff[addr_ff][7];
                            nxt_sh = mem_ff[addr_ff];
                        end else begin
                            nxt_st = SEE_IDLE;
                        end
                    end
                end else if (st_ff == SEE_RACK) begin
                    nxt_bit = bit_ff + 4'h1;
                    if (bit_ff == 4'h7) begin
                        nxt_ack  = 1'b1;
                        nxt_st   = SEE_READ;
                        nxt_addr = addr_inc(addr_ff);
                    end else begin
                        nxt_oe = !sh_ff[6 - bit_ff[2:0]];
                    end
                end else if (bit_ff == 4'h8) begin
                    nxt_ack = 1'b1;
                    unique case (st_ff)
                        SEE_ADDR: begin
                            if (sh_ff[7:1] == {SEE_DEV_CODE, SEE_DEV_SEL} && !busy_ff) begin
                                nxt_oe = 1'b1;
                                nxt_rd = sh_ff[0];
                                nxt_st = sh_ff[0] ? SEE_READ : SEE_WORD;
                            end else begin
                                nxt_st = SEE_IDLE;
                                nxt_ack = 1'b0;
                            end
                        end
                        SEE_WORD: begin
                            nxt_oe   = 1'b1;
                            nxt_addr = sh_ff;
                            nxt_st   = SEE_DATA;
                            nxt_wpl  = wp_sy_ff[1];
                        end
                        SEE_DATA: begin
                            if (!wpl_ff) begin
                                nxt_oe = 1'b1;
                                nxt_dirty = 1'b1;
                                nxt_pval[addr_ff[3:0]] = 1'b1;
                                nxt_addr = {addr_ff[7:4], addr_ff[3:0] + 4'h1};
                            end else begin
                                nxt_st = SEE_IDLE;
                            end
                        end
                        default: nxt_st = SEE_IDLE;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_sy_ff <= 3'h7; sda_sy_ff <= 3'h7; scl_d_ff <= 1'b1; sda_d_ff <= 1'b1;
            st_ff <= SEE_IDLE; bit_ff <= 4'h0; sh_ff <= 8'h00; ack_ff <= 1'b0;
            rd_ff <= 1'b0; addr_ff <= 8'h00; wpl_ff <= 1'b0; dirty_ff <= 1'b0;
            oe_ff <= 1'b0; mack_ff <= 1'b0; pval_ff <= '0; wcnt_ff <= 32'h0;
            rcnt_ff <= 32'h0; busy_ff <= 1'b0; ready_ff <= 1'b0;
            wp_sy_ff <= 2'h0;
        end else begin
            wp_sy_ff <= {wp_sy_ff[0], wp};
            scl_sy_ff <= {scl_sy_ff[1:0], bus.scl_o};
            sda_sy_ff <= {sda_sy_ff[1:0], bus.sda};
            scl_d_ff <= scl; sda_d_ff <= sda;
            st_ff <= nxt_st; bit_ff <= nxt_bit; sh_ff <= nxt_sh; ack_ff <= nxt_ack;
            rd_ff <= nxt_rd; addr_ff <= nxt_addr; wpl_ff <= nxt_wpl; dirty_ff <= nxt_dirty;
            oe_ff <= nxt_oe; mack_ff <= nxt_mack; pval_ff <= nxt_pval; wcnt_ff <= nxt_wcnt;
            rcnt_ff <= nxt_rcnt; busy_ff <= nxt_busy; ready_ff <= nxt_ready;
        end
    end

    // Page buffer and array; array keeps content across reset
    always_ff @(posedge clk) begin
        if (st_ff == SEE_DATA && scl_fall && !ack_ff && bit_ff == 4'h8 && !wpl_ff)
            pbuf_ff[addr_ff[3:0]] <= sh_ff;
        if (commit) begin
            for (int i = 0; i < SEE_PAGE_BYTES; i++) begin
                if (pval_ff[i])
                    mem_ff[{addr_ff[7:4], 4'(i)}] <= pbuf_ff[i];
            end
        end
    end
endmodule : see_slave

//--- logic/see_master.sv
// Bus master end: sends one byte or reads one byte with the given start/stop framing
module see_master
    import see_pkg::*;
#(
    parameter int HALF = MST_HALF_CYCLES
) (
    input  wire logic   clk,
    input  wire logic   rst_n,
    see_bus_if.master   bus,
    input  wire logic   req,
    input  wire logic   do_start,
    input  wire logic   do_stop,
    input  wire logic   do_read,
    input  wire logic   ack_out,
    input  wire logic [7:0] wdata,
    output logic [7:0]  rdata,
    output logic        got_ack,
    output logic        done
);
    see_mst_state_t st_ff, nxt_st;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [1:0]  ph_ff, nxt_ph;
    logic [3:0]  bit_ff, nxt_bit;
    logic [8:0]  sh_ff, nxt_sh;
    logic [8:0]  rx_ff, nxt_rx;
    logic        scl_ff, nxt_scl, sdo_ff, nxt_sdo, stop_ff, nxt_stop;
    logic [1:0]  sy_ff;
    logic        done_ff, nxt_done;
    logic        tick;

    assign tick = (cnt_ff == 16'(HALF - 1));
    assign bus.scl_o    = scl_ff;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = !sdo_ff;
    assign rdata   = rx_ff[8:1];
    assign got_ack = !rx_ff[0];
    assign done    = done_ff;

    always_comb begin
        nxt_st = st_ff; nxt_ph = ph_ff; nxt_bit = bit_ff; nxt_sh = sh_ff; nxt_rx = rx_ff;
        nxt_scl = scl_ff; nxt_sdo = sdo_ff; nxt_stop = stop_ff; nxt_done = 1'b0;
        nxt_cnt = tick ? 16'h0 : cnt_ff + 16'h1;
        if (st_ff == MST_IDLE) nxt_cnt = 16'h0;
        unique case (st_ff)
            MST_IDLE: if (req) begin
                nxt_stop = do_stop;
                nxt_sh   = do_read ? {8'hff, !ack_out} : {wdata, 1'b1};
                nxt_bit  = 4'h0; nxt_ph = 2'h0;
                nxt_st   = do_start ? MST_START : MST_BITS;
            end
            MST_START: if (tick) begin
                nxt_ph = ph_ff + 2'h1;
                unique case (ph_ff)
                    2'h0: begin nxt_sdo = 1'b1; nxt_scl = 1'b0; end
                    2'h1: nxt_scl = 1'b1;
                    2'h2: nxt_sdo = 1'b0;
                    default: begin nxt_scl = 1'b0; nxt_ph = 2'h0; nxt_st = MST_BITS; end
                endcase
            end
            MST_BITS: if (tick) begin
                nxt_ph = ph_ff + 2'h1;
                unique case (ph_ff)
                    2'h0: nxt_sdo = sh_ff[8];
                    2'h1: nxt_scl = 1'b1;
                    2'h2: nxt_rx = {rx_ff[7:0], sy_ff[1]};
                    default: begin
                        nxt_scl = 1'b0; nxt_ph = 2'h0;
                        nxt_sh = {sh_ff[7:0], 1'b1};
                        nxt_bit = bit_ff + 4'h1;
                        if (bit_ff == 4'h8) nxt_st = stop_ff ? MST_STOP : MST_DONE;
                    end
                endcase
            end
            MST_STOP: if (tick) begin
                nxt_ph = ph_ff + 2'h1;
                unique case (ph_ff)
                    2'h0: nxt_sdo = 1'b0;
                    2'h1: nxt_scl = 1'b1;
                    2'h2: nxt_sdo = 1'b1;
                    default: begin nxt_ph = 2'h0; nxt_st = MST_DONE; end
                endcase
            end
            MST_DONE: begin nxt_done = 1'b1; nxt_st = MST_IDLE; end
            default: nxt_st = MST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff <= MST_IDLE; cnt_ff <= 16'h0; ph_ff <= 2'h0; bit_ff <= 4'h0;
            sh_ff <= 9'h1ff; rx_ff <= 9'h1ff; scl_ff <= 1'b1; sdo_ff <= 1'b1;
            stop_ff <= 1'b0; sy_ff <= 2'h3; done_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st; cnt_ff <= nxt_cnt; ph_ff <= nxt_ph; bit_ff <= nxt_bit;
            sh_ff <= nxt_sh; rx_ff <= nxt_rx; scl_ff <= nxt_scl; sdo_ff <= nxt_sdo;
            stop_ff <= nxt_stop; sy_ff <= {sy_ff[0], bus.sda}; done_ff <= nxt_done;
        end
    end
endmodule : see_master

//--- verif/see_properties.sv
// Bus and status checks for the serial EEPROM slave
module see_properties #(
    parameter int READY_TIME = 20,
    parameter int WRITE_TIME = 2000
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_o,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic sda,
    input wire logic busy,
    input wire logic ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int         up_ff;
    int         nxt_up;
    int         bsy_ff;
    int         nxt_bsy;
    logic [3:0] stp_ff;
    logic [3:0] nxt_stp;
    logic       scl_ff;
    logic       sda_ff;

    always_comb begin
        nxt_up = (up_ff < 100000) ? up_ff + 1 : up_ff;
        nxt_bsy = busy ? bsy_ff + 1 : 0;
        nxt_stp = (stp_ff == 4'hf) ? stp_ff : stp_ff + 4'h1;
        // Stop seen on the wire
        if (scl_o && scl_ff && sda && !sda_ff) begin
            nxt_stp = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            up_ff <= 0;
            bsy_ff <= 0;
            stp_ff <= 4'hf;
        end else begin
            up_ff <= nxt_up;
            bsy_ff <= nxt_bsy;
            stp_ff <= nxt_stp;
        end
        scl_ff <= scl_o;
        sda_ff <= sda;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_pull_only: assert property (sda_s_oe |-> !sda_s_o)
        else $error("slave drives data high");
    chk_quiet_unready: assert property (!ready |-> !sda_s_oe)
        else $error("slave drives before ready");
    chk_change_clock_low: assert property ($changed(sda_s_oe) |-> !scl_o && !$past(scl_o, 2))
        else $error("slave data changed near high clock");
    chk_busy_silent: assert property (busy |-> !sda_s_oe)
        else $error("slave drives while busy");
    chk_release_clear: assert property ($rose(rst_n) |-> !busy && !ready && !sda_s_oe)
        else $error("state not cleared by reset");
    chk_ready_bound: assert property (up_ff > READY_TIME + 2 |-> ready)
        else $error("ready late after reset");
    chk_write_length: assert property ($fell(busy) |-> bsy_ff >= WRITE_TIME - 2 && bsy_ff <= WRITE_TIME + 2)
        else $error("write cycle length wrong");
    chk_busy_bounded: assert property (bsy_ff <= WRITE_TIME + 2)
        else $error("write cycle never ends");
    chk_write_on_stop: assert property ($rose(busy) |-> stp_ff < 4'h8)
        else $error("write cycle without stop");
endmodule : see_properties

//--- verif/see_slave_tb.sv
// Self-checking bench: master and slave ends joined on one bus
module see_slave_tb
    import see_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         RT = 20;
    localparam int         WT = 2000;
    localparam logic [7:0] AW = {SEE_DEV_CODE, SEE_DEV_SEL, 1'b0};
    localparam logic [7:0] AR = {SEE_DEV_CODE, SEE_DEV_SEL, 1'b1};
    logic       clk, rst_n, wp, req, do_start, do_stop, do_read, ack_out;
    logic [7:0] wdata, rdata, wa, base;
    logic       got_ack, done, busy, ready;
    logic [7:0] mem [256];
    int         err_count, check_count, n;

    see_bus_if bus_if ();
    see_slave #(.MEM_BYTES(256), .WRITE_TIME(WT), .READY_TIME(RT)) see_slave_inst (.clk(clk), .rst_n(rst_n),
        .bus(bus_if), .wp(wp), .busy(busy), .ready(ready));
    see_master #(.HALF(16)) see_master_inst (.clk(clk), .rst_n(rst_n), .bus(bus_if), .req(req),
        .do_start(do_start), .do_stop(do_stop), .do_read(do_read), .ack_out(ack_out), .wdata(wdata),
        .rdata(rdata), .got_ack(got_ack), .done(done));
    see_properties #(.READY_TIME(RT), .WRITE_TIME(WT)) see_properties_inst (.clk(clk), .rst_n(rst_n),
        .scl_o(bus_if.scl_o), .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe), .sda(bus_if.sda),
        .busy(busy), .ready(ready));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [7:0] pg(input logic [7:0] w, input int i);
        return {w[7:4], w[3:0] + 4'(i)};
    endfunction : pg

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic ackchk(input logic e);
        chk({7'h00, got_ack}, {7'h00, e});
    endtask : ackchk

    task automatic xfer(input logic s, input logic p, input logic r, input logic a, input logic [7:0] d);
        int k;
        repeat (2) @(negedge clk);
        req = 1'b1;
        do_start = s;
        do_stop = p;
        do_read = r;
        ack_out = a;
        wdata = d;
        @(negedge clk);
        req = 1'b0;
        for (k = 0; k < 4000 && done !== 1'b1; k++) @(negedge clk);
        chk({7'h00, done}, 8'h01);
    endtask : xfer

    task automatic rd(input logic sel, input logic [7:0] w, input int cnt);
        if (sel) begin
            xfer(1'b1, 1'b0, 1'b0, 1'b1, AW);
            ackchk(1'b1);
            xfer(1'b0, 1'b0, 1'b0, 1'b1, w);
            ackchk(1'b1);
        end
        xfer(1'b1, 1'b0, 1'b0, 1'b1, AR);
        ackchk(1'b1);
        for (int i = 0; i < cnt; i++) begin
            xfer(1'b0, 1'(i == cnt - 1), 1'b1, 1'(i != cnt - 1), 8'h00);
            chk(rdata, mem[8'(w + 8'(i))]);
        end
    endtask : rd

    task automatic wait_ready;
        for (n = 0; n < RT + 10 && ready !== 1'b1; n++) @(negedge clk);
        chk({7'h00, ready}, 8'h01);
    endtask : wait_ready

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        final_report();
    end

    initial begin
        {rst_n, wp, req, do_start, do_stop, do_read, ack_out} = 7'h00;
        wdata = 8'h00;
        err_count = 0;
        check_count = 0;
        foreach (mem[i]) mem[i] = SEE_ERASED;
        void'($urandom(32'h38d370d5));
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        wait_ready();
        rd(1'b0, 8'h00, 1);
        $display("test immediate read done");
        for (int i = 0; i < 4; i++) begin
            wa = (i == 0) ? 8'ha2 : 8'($urandom);
            if (wa[7:1] == AW[7:1]) wa[3] = 1'b1;
            xfer(1'b1, 1'b1, 1'b0, 1'b0, wa);
            ackchk(1'b0);
        end
        $display("test foreign address done");
        base = 8'($urandom);
        xfer(1'b1, 1'b0, 1'b0, 1'b1, AW);
        ackchk(1'b1);
        xfer(1'b0, 1'b0, 1'b0, 1'b1, base);
        ackchk(1'b1);
        for (int i = 0; i < 18; i++) begin
            wa = 8'($urandom);
            xfer(1'b0, 1'(i == 17), 1'b0, 1'b1, wa);
            ackchk(1'b1);
            mem[pg(base, i)] = wa;
        end
        n = 0;
        do begin
            xfer(1'b1, 1'b1, 1'b0, 1'b0, AW);
            n++;
        end while (got_ack !== 1'b1 && n < 50);
        chk(8'(n > 1), 8'h01);
        rd(1'b1, {base[7:4], 4'h0}, 16);
        $display("test page write done");
        wp = 1'b1;
        xfer(1'b1, 1'b0, 1'b0, 1'b1, AW);
        ackchk(1'b1);
        xfer(1'b0, 1'b0, 1'b0, 1'b1, base);
        ackchk(1'b1);
        xfer(1'b0, 1'b1, 1'b0, 1'b1, ~mem[base]);
        ackchk(1'b0);
        repeat (20) @(negedge clk);
        chk({7'h00, busy}, 8'h00);
        wp = 1'b0;
        rd(1'b1, base, 1);
        $display("test write protect done");
        xfer(1'b1, 1'b0, 1'b0, 1'b1, AW);
        xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'hff);
        repeat (20) @(negedge clk);
        chk({7'h00, busy}, 8'h00);
        rd(1'b0, 8'hff, 2);
        $display("test address only and wrap done");
        rst_n = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        chk({7'h00, ready}, 8'h00);
        wait_ready();
        xfer(1'b1, 1'b1, 1'b0, 1'b0, AW);
        ackchk(1'b1);
        $display("test second reset done");
        final_report();
    end
endmodule : see_slave_tb
